// >>> rtl/hwt_params.svh
// Register map, reset values and widths of the haptic waveform timing registers
`ifndef HWT_PARAMS_SVH
`define HWT_PARAMS_SVH

`define HWT_DW            8
`define HWT_TIME_W        17

`define HWT_OFS_NEG_SUS   8'h0f
`define HWT_OFS_BRAKE     8'h10
`define HWT_OFS_RATED     8'h16
`define HWT_OFS_CLAMP     8'h17
`define HWT_OFS_CAL_COMP  8'h18
`define HWT_OFS_CAL_BEMF  8'h19

`define HWT_RST_NEG_SUS   8'h00
`define HWT_RST_BRAKE     8'h00
`define HWT_RST_RATED     8'h3e
`define HWT_RST_CLAMP     8'h9b
`define HWT_RST_CAL_COMP  8'h0c
`define HWT_RST_CAL_BEMF  8'h6c
`define HWT_RD_UNMAPPED   8'h00

// Serial port device address, arbitrary value
`define HWT_DEV_ADDR      7'h2a

`endif

// >>> rtl/hwt_pkg.sv
// Types shared by the haptic waveform timing register block
`include "hwt_params.svh"
package hwt_pkg;

  typedef struct packed {
    logic [`HWT_DW-1:0] addr;
    logic [`HWT_DW-1:0] data;
  } hwt_wr_t;

  typedef struct packed {
    logic signed [`HWT_DW-1:0] amp;
    logic        [`HWT_DW-1:0] steps;
    logic signed [`HWT_DW-1:0] peak;
    logic signed [`HWT_DW-1:0] trough;
  } hwt_seg_t;

  typedef enum logic [2:0] {
    HWT_CLS_IDLE     = 3'h0,
    HWT_CLS_OVERDRV  = 3'h1,
    HWT_CLS_POS_SUS  = 3'h2,
    HWT_CLS_NEG_SUS  = 3'h3,
    HWT_CLS_BRAKE    = 3'h4
  } hwt_cls_t;

  typedef enum logic [5:0] {
    HWT_SP_IDLE = 6'b000001,
    HWT_SP_ADDR = 6'b000010,
    HWT_SP_WACK = 6'b000100,
    HWT_SP_RX   = 6'b001000,
    HWT_SP_TX   = 6'b010000,
    HWT_SP_RACK = 6'b100000
  } hwt_sp_state_t;

endpackage : hwt_pkg

// >>> rtl/hwt_serial_port.sv
// Two-wire serial register port: address match, pointer, write strobe, read load
`timescale 1ns/100ps
`include "hwt_params.svh"
module hwt_serial_port (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // Pins
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe_o,
  // Register side
  output logic                     wr_stb_o,
  output hwt_pkg::hwt_wr_t         wr_o,
  output logic [`HWT_DW-1:0]       rd_addr_o,
  input  wire logic [`HWT_DW-1:0]  rd_data_i
);
  import hwt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] scl_q, sda_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
    end
  end

  // Edges judged on stages two and three only
  logic scl_rise, scl_fall, start_ev, stop_ev, sda_s;
  assign sda_s    = sda_q[1];
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_ev = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_ev  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  ////////////////////////////////////////////////////////////////////////////
  hwt_sp_state_t      st_q, st_d;
  logic [3:0]         cnt_q, cnt_d;
  logic [`HWT_DW-1:0] sh_q, sh_d, ptr_q, ptr_d;
  logic               rw_q, rw_d, first_q, first_d, ack_q, ack_d, oe_q, oe_d;
  logic               stb_d;
  hwt_wr_t            wr_q, wr_d;
  logic               stb_q;

  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; ptr_d = ptr_q; rw_d = rw_q;
    first_d = first_q; ack_d = ack_q; oe_d = oe_q; stb_d = 1'b0; wr_d = wr_q;
    if (start_ev) begin
      st_d = HWT_SP_ADDR; cnt_d = 4'h0; oe_d = 1'b0;
    end else if (stop_ev) begin
      st_d = HWT_SP_IDLE; oe_d = 1'b0;
    end else if (scl_rise) begin
      case (st_q)
        HWT_SP_ADDR, HWT_SP_RX: begin
          sh_d  = {sh_q[6:0], sda_s};
          cnt_d = cnt_q + 4'h1;
        end
        HWT_SP_RACK: ack_d = ~sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_q)
        HWT_SP_ADDR: if (cnt_q == 4'h8) begin
          if (sh_q[7:1] == `HWT_DEV_ADDR) begin
            st_d = HWT_SP_WACK; oe_d = 1'b1; rw_d = sh_q[0]; first_d = 1'b1;
          end else begin
            st_d = HWT_SP_IDLE;
          end
        end
        HWT_SP_RX: if (cnt_q == 4'h8) begin
          st_d = HWT_SP_WACK; oe_d = 1'b1;
          if (first_q) begin
            ptr_d = sh_q; first_d = 1'b0;
          end else begin
            stb_d = 1'b1; wr_d = '{addr: ptr_q, data: sh_q};
            ptr_d = ptr_q + 8'h01;
          end
        end
        HWT_SP_WACK, HWT_SP_RACK: begin
          if (rw_q && (st_q == HWT_SP_WACK || ack_q)) begin
            st_d = HWT_SP_TX; sh_d = rd_data_i; oe_d = ~rd_data_i[7];
            cnt_d = 4'h1; ptr_d = ptr_q + 8'h01;
          end else if (rw_q) begin
            st_d = HWT_SP_IDLE; oe_d = 1'b0;
          end else begin
            st_d = HWT_SP_RX; oe_d = 1'b0; cnt_d = 4'h0;
          end
        end
        HWT_SP_TX: if (cnt_q == 4'h8) begin
          st_d = HWT_SP_RACK; oe_d = 1'b0;
        end else begin
          sh_d = {sh_q[6:0], 1'b0}; oe_d = ~sh_q[6]; cnt_d = cnt_q + 4'h1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= HWT_SP_IDLE; cnt_q <= 4'h0; sh_q <= 8'h00; ptr_q <= 8'h00;
      rw_q <= 1'b0; first_q <= 1'b0; ack_q <= 1'b0; oe_q <= 1'b0;
      stb_q <= 1'b0; wr_q <= '0; sda_o <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; ptr_q <= ptr_d;
      rw_q <= rw_d; first_q <= first_d; ack_q <= ack_d; oe_q <= oe_d;
      stb_q <= stb_d; wr_q <= wr_d; sda_o <= 1'b0;
    end
  end

  assign sda_oe_o  = oe_q;
  assign wr_stb_o  = stb_q;
  assign wr_o      = wr_q;
  assign rd_addr_o = ptr_q;

endmodule : hwt_serial_port

// >>> rtl/hwt_regs.sv
// Waveform timing offset, rated voltage, overdrive clamp and calibration registers
//
// Functional notes
// - Negative sustain segments are stretched or cut by the offset times the step interval.
// - The negative sustain offset is a signed two's complement number.
// - Every negative drive value other than the overdrive and brake ones counts as negative sustain.
// - Brake segments are adjusted by the signed brake offset times the step interval.
// - The most negative drive value of a waveform is its brake portion.
// - The brake offset is applied only in open loop and ignored in closed loop.
// - Rated voltage is the closed-loop full-scale reference and resets to 0x3e.
// - Rated voltage is ignored in open loop, where the clamp is the reference.
// - In closed loop, automatic overdrive and braking may drive above rated voltage.
// - Automatic overdrive is limited to the overdrive clamp, which resets to 0x9b.
// - The overdrive clamp is the full-scale reference in open loop.
// - The largest drive value of a waveform is its overdrive portion, never sustain.
`timescale 1ns/100ps
`include "hwt_params.svh"
module hwt_regs (
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  // Serial register port pins
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_o,
  // Playback engine side
  input  wire logic                    open_loop_i,
  input  wire logic [`HWT_DW-1:0]      playback_step_interval_i,
  input  wire logic                    seg_valid_i,
  input  hwt_pkg::hwt_seg_t            seg_i,
  output logic                         seg_valid_o,
  output hwt_pkg::hwt_cls_t            seg_class_o,
  output logic [`HWT_TIME_W-1:0]       seg_time_ms_o,
  // Drive level limiting
  input  wire logic                    auto_period_i,
  input  wire logic [`HWT_DW-1:0]      fb_drive_i,
  output logic [`HWT_DW-1:0]           drive_level_o,
  output logic [`HWT_DW-1:0]           full_scale_ref_o,
  // Calibration engine side
  input  wire logic                    cal_done_i,
  input  wire logic [`HWT_DW-1:0]      cal_comp_i,
  input  wire logic [`HWT_DW-1:0]      calibration_back_emf_result_i,
  output logic [`HWT_DW-1:0]           cal_rated_o,
  output logic                         cal_stale_o
);
  import hwt_pkg::*;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  ////////////////////////////////////////////////////////////////////////////
  logic               wr_stb;
  hwt_wr_t            wr;
  logic [`HWT_DW-1:0] rd_addr, rd_data;

  hwt_serial_port u_port (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe_o  (sda_oe_o),
    .wr_stb_o  (wr_stb),
    .wr_o      (wr),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic signed [`HWT_DW-1:0] negative_sustain_offset_q, negative_sustain_offset_d;
  logic signed [`HWT_DW-1:0] brake_time_offset_q, brake_time_offset_d;
  logic [`HWT_DW-1:0]        rated_voltage_q, rated_voltage_d;
  logic [`HWT_DW-1:0]        overdrive_clamp_level_q, overdrive_clamp_level_d;
  logic [`HWT_DW-1:0]        cal_comp_q, cal_comp_d;
  logic [`HWT_DW-1:0]        calibration_back_emf_result_q, calibration_back_emf_result_d;
  logic                      stale_q, stale_d;

  always_comb begin
    negative_sustain_offset_d     = negative_sustain_offset_q;
    brake_time_offset_d           = brake_time_offset_q;
    rated_voltage_d               = rated_voltage_q;
    overdrive_clamp_level_d       = overdrive_clamp_level_q;
    cal_comp_d                    = cal_comp_q;
    calibration_back_emf_result_d = calibration_back_emf_result_q;
    stale_d                       = stale_q;
    if (cal_done_i) begin
      stale_d = 1'b0;
    end
    if (wr_stb) begin
      case (wr.addr)
        `HWT_OFS_NEG_SUS:  negative_sustain_offset_d     = wr.data;
        `HWT_OFS_BRAKE:    brake_time_offset_d           = wr.data;
        `HWT_OFS_RATED: begin
          rated_voltage_d = wr.data;
          stale_d         = 1'b1;
        end
        `HWT_OFS_CLAMP:    overdrive_clamp_level_d       = wr.data;
        `HWT_OFS_CAL_COMP: cal_comp_d                    = wr.data;
        `HWT_OFS_CAL_BEMF: calibration_back_emf_result_d = wr.data;
        default: ;
      endcase
    end
    // Fresh calibration results override a host write in the same cycle
    if (cal_done_i) begin
      cal_comp_d                    = cal_comp_i;
      calibration_back_emf_result_d = calibration_back_emf_result_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      negative_sustain_offset_q     <= `HWT_RST_NEG_SUS;
      brake_time_offset_q           <= `HWT_RST_BRAKE;
      rated_voltage_q               <= `HWT_RST_RATED;
      overdrive_clamp_level_q       <= `HWT_RST_CLAMP;
      cal_comp_q                    <= `HWT_RST_CAL_COMP;
      calibration_back_emf_result_q <= `HWT_RST_CAL_BEMF;
      stale_q                       <= 1'b0;
    end else begin
      negative_sustain_offset_q     <= negative_sustain_offset_d;
      brake_time_offset_q           <= brake_time_offset_d;
      rated_voltage_q               <= rated_voltage_d;
      overdrive_clamp_level_q       <= overdrive_clamp_level_d;
      cal_comp_q                    <= cal_comp_d;
      calibration_back_emf_result_q <= calibration_back_emf_result_d;
      stale_q                       <= stale_d;
    end
  end

  always_comb begin
    case (rd_addr)
      `HWT_OFS_NEG_SUS:  rd_data = negative_sustain_offset_q;
      `HWT_OFS_BRAKE:    rd_data = brake_time_offset_q;
      `HWT_OFS_RATED:    rd_data = rated_voltage_q;
      `HWT_OFS_CLAMP:    rd_data = overdrive_clamp_level_q;
      `HWT_OFS_CAL_COMP: rd_data = cal_comp_q;
      `HWT_OFS_CAL_BEMF: rd_data = calibration_back_emf_result_q;
      default:           rd_data = `HWT_RD_UNMAPPED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Segment classification and time adjustment
  hwt_cls_t                  cls;
  logic signed [`HWT_DW-1:0] adj;
  logic signed [9:0]         sum;
  logic [8:0]                steps_adj;
  logic [`HWT_TIME_W-1:0]    time_d;

  always_comb begin
    if (seg_i.amp == seg_i.peak && seg_i.amp != 8'sh00) begin
      cls = HWT_CLS_OVERDRV;
    end else if (seg_i.amp == seg_i.trough && seg_i.amp < 8'sh00) begin
      cls = HWT_CLS_BRAKE;
    end else if (seg_i.amp < 8'sh00) begin
      cls = HWT_CLS_NEG_SUS;
    end else if (seg_i.amp > 8'sh00) begin
      cls = HWT_CLS_POS_SUS;
    end else begin
      cls = HWT_CLS_IDLE;
    end
    case (cls)
      HWT_CLS_NEG_SUS: adj = negative_sustain_offset_q;
      HWT_CLS_BRAKE:   adj = open_loop_i ? brake_time_offset_q : 8'sh00;
      default:         adj = 8'sh00;
    endcase
    // Signed extension of the offset; a negative total clips to zero time
    sum       = $signed({2'b00, seg_i.steps}) + 10'(adj);
    steps_adj = sum[9] ? 9'h000 : sum[8:0];
    time_d    = steps_adj * playback_step_interval_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Full-scale reference and drive limiting
  logic [`HWT_DW-1:0] ref_d, lim, lvl_d;

  always_comb begin
    ref_d = open_loop_i ? overdrive_clamp_level_q : rated_voltage_q;
    // Auto overdrive and braking may pass rated voltage but never the clamp
    lim   = (open_loop_i || auto_period_i) ? overdrive_clamp_level_q
                                           : rated_voltage_q;
    lvl_d = (fb_drive_i > lim) ? lim : fb_drive_i;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      seg_valid_o      <= 1'b0;
      seg_class_o      <= HWT_CLS_IDLE;
      seg_time_ms_o    <= '0;
      full_scale_ref_o <= `HWT_RST_RATED;
      drive_level_o    <= 8'h00;
      cal_rated_o      <= `HWT_RST_RATED;
      cal_stale_o      <= 1'b0;
    end else begin
      seg_valid_o      <= seg_valid_i;
      seg_class_o      <= seg_valid_i ? cls : seg_class_o;
      seg_time_ms_o    <= seg_valid_i ? time_d : seg_time_ms_o;
      full_scale_ref_o <= ref_d;
      drive_level_o    <= lvl_d;
      cal_rated_o      <= rated_voltage_q;
      cal_stale_o      <= stale_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_neg_seg;
    seg_valid_i && seg_i.amp < 8'sh00 && seg_i.amp != seg_i.trough && seg_i.amp != seg_i.peak;
  endsequence

  a_reset_values: assert property (@(posedge clk_i) disable iff (1'b0)
    $past(sys_rst_i) |-> rated_voltage_q == 8'h3e && overdrive_clamp_level_q == 8'h9b)
    else $error("rated or clamp reset value wrong");
  a_ref_closed: assert property (!open_loop_i |=> full_scale_ref_o == $past(rated_voltage_q))
    else $error("closed loop reference not rated voltage");
  a_ref_open: assert property (open_loop_i |=> full_scale_ref_o == $past(overdrive_clamp_level_q))
    else $error("open loop reference not clamp");
  a_clamp_bound: assert property (1'b1 |=> drive_level_o <= $past(overdrive_clamp_level_q))
    else $error("drive above overdrive clamp");
  a_rated_bound: assert property (!open_loop_i && !auto_period_i
    |=> drive_level_o <= $past(rated_voltage_q))
    else $error("closed loop drive above rated outside auto period");
  a_brake_class: assert property (seg_valid_i && seg_i.amp == seg_i.trough
    && seg_i.amp < 8'sh00 && seg_i.peak != seg_i.amp |=> seg_class_o == HWT_CLS_BRAKE)
    else $error("most negative value not brake");
  a_od_class: assert property (seg_valid_i && seg_i.amp == seg_i.peak && seg_i.amp > 8'sh00
    |=> seg_class_o == HWT_CLS_OVERDRV)
    else $error("largest value not overdrive");
  a_negsus_class: assert property (s_neg_seg |=> seg_class_o == HWT_CLS_NEG_SUS)
    else $error("negative value not sustain");
  a_negsus_time: assert property ((s_neg_seg
    and ((int'(seg_i.steps) + int'(negative_sustain_offset_q)) >= 0))
    |=> int'(seg_time_ms_o) == (int'($past(seg_i.steps)) + int'($past(negative_sustain_offset_q)))
        * int'($past(playback_step_interval_i)))
    else $error("negative sustain time offset wrong");
  a_brake_closed: assert property (seg_valid_i && !open_loop_i && cls == HWT_CLS_BRAKE
    |=> int'(seg_time_ms_o) == int'($past(seg_i.steps)) * int'($past(playback_step_interval_i)))
    else $error("brake offset applied in closed loop");
  a_brake_open: assert property (seg_valid_i && open_loop_i && cls == HWT_CLS_BRAKE
    && (int'(seg_i.steps) + int'(brake_time_offset_q)) >= 0
    |=> int'(seg_time_ms_o) == (int'($past(seg_i.steps)) + int'($past(brake_time_offset_q)))
        * int'($past(playback_step_interval_i)))
    else $error("open loop brake offset wrong");

endmodule : hwt_regs

// >>> sim/hwt_regs_test.sv
// Self-checking bench for the haptic waveform timing register block
`timescale 1ns/100ps
`include "hwt_params.svh"
module hwt_regs_test;
  import hwt_pkg::*;

  localparam int HALF = 12;

  logic                   clk_i                         = 1'b0;
  logic                   sys_rst_i                     = 1'b1;
  logic                   scl_m                         = 1'b1;
  logic                   sda_m                         = 1'b1;
  logic                   sda_w;
  logic                   sda_o;
  logic                   sda_oe_o;
  logic                   open_loop_i                   = 1'b0;
  logic [7:0]             playback_step_interval_i      = 8'h05;
  logic                   seg_valid_i                   = 1'b0;
  hwt_seg_t               seg_i                         = '0;
  logic                   seg_valid_o;
  hwt_cls_t               seg_class_o;
  logic [`HWT_TIME_W-1:0] seg_time_ms_o;
  logic                   auto_period_i                 = 1'b0;
  logic [7:0]             fb_drive_i                    = 8'h00;
  logic [7:0]             drive_level_o;
  logic [7:0]             full_scale_ref_o;
  logic                   cal_done_i                    = 1'b0;
  logic [7:0]             cal_comp_i                    = 8'h00;
  logic [7:0]             calibration_back_emf_result_i = 8'h00;
  logic [7:0]             cal_rated_o;
  logic                   cal_stale_o;
  int                     err_count                     = 0;
  int                     checked                       = 0;

  `define CHK(nm, exp, act) begin checked++; if ((act) !== (exp)) begin err_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, act); end end

  always #4 clk_i = ~clk_i;

  // Open-drain data line with pull-up: either party may pull it low
  assign sda_w = sda_m & ~(sda_oe_o & ~sda_o);

  hwt_regs u_hwt_regs (
    .clk_i                         (clk_i),
    .sys_rst_i                     (sys_rst_i),
    .scl_i                         (scl_m),
    .sda_i                         (sda_w),
    .sda_o                         (sda_o),
    .sda_oe_o                      (sda_oe_o),
    .open_loop_i                   (open_loop_i),
    .playback_step_interval_i      (playback_step_interval_i),
    .seg_valid_i                   (seg_valid_i),
    .seg_i                         (seg_i),
    .seg_valid_o                   (seg_valid_o),
    .seg_class_o                   (seg_class_o),
    .seg_time_ms_o                 (seg_time_ms_o),
    .auto_period_i                 (auto_period_i),
    .fb_drive_i                    (fb_drive_i),
    .drive_level_o                 (drive_level_o),
    .full_scale_ref_o              (full_scale_ref_o),
    .cal_done_i                    (cal_done_i),
    .cal_comp_i                    (cal_comp_i),
    .calibration_back_emf_result_i (calibration_back_emf_result_i),
    .cal_rated_o                   (cal_rated_o),
    .cal_stale_o                   (cal_stale_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick

  // Works both from idle and as a repeated start with the clock low
  task automatic bus_start();
    sda_m = 1'b1;
    tick(HALF);
    scl_m = 1'b1;
    tick(HALF);
    sda_m = 1'b0;
    tick(HALF);
    scl_m = 1'b0;
    tick(HALF);
  endtask : bus_start

  task automatic bus_stop();
    sda_m = 1'b0;
    tick(HALF);
    scl_m = 1'b1;
    tick(HALF);
    sda_m = 1'b1;
    tick(HALF);
  endtask : bus_stop

  // Phases of ten clocks or more keep the three-stage pin sampling safe
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    tick(HALF);
    scl_m = 1'b1;
    tick(HALF);
    r = sda_w;
    scl_m = 1'b0;
    tick(HALF);
  endtask : bit_io

  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, a);
    ack = ~a;
  endtask : byte_io

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] rx;
    logic       a0, a1, a2;
    bus_start();
    byte_io({`HWT_DEV_ADDR, 1'b0}, rx, a0);
    byte_io(addr, rx, a1);
    byte_io(data, rx, a2);
    bus_stop();
    `CHK("write acks", 3'b111, {a0, a1, a2})
  endtask : reg_write

  task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp, input string nm);
    logic [7:0] rx;
    logic [7:0] data;
    logic       a0, a1, a2, nack;
    bus_start();
    byte_io({`HWT_DEV_ADDR, 1'b0}, rx, a0);
    byte_io(addr, rx, a1);
    bus_start();
    byte_io({`HWT_DEV_ADDR, 1'b1}, rx, a2);
    byte_io(8'hff, data, nack);
    bus_stop();
    `CHK("read acks", 3'b111, {a0, a1, a2})
    `CHK(nm, exp, data)
  endtask : check_reg

  task automatic ref_case(input logic ol, input logic ap, input logic [7:0] fb,
                          input logic [7:0] exp_drv, input logic [7:0] exp_fs);
    open_loop_i   = ol;
    auto_period_i = ap;
    fb_drive_i    = fb;
    tick(2);
    `CHK("drive level", exp_drv, drive_level_o)
    `CHK("full scale", exp_fs, full_scale_ref_o)
  endtask : ref_case

  task automatic run_seg(input logic [7:0] amp, input logic [7:0] steps, input logic [7:0] pk,
                         input logic [7:0] tr, input logic ol, input hwt_cls_t cls,
                         input logic [`HWT_TIME_W-1:0] tms);
    open_loop_i = ol;
    seg_i       = '{amp: amp, steps: steps, peak: pk, trough: tr};
    seg_valid_i = 1'b1;
    tick(1);
    seg_valid_i = 1'b0;
    `CHK("segment valid", 1'b1, seg_valid_o)
    `CHK("segment class", cls, seg_class_o)
    `CHK("segment time", tms, seg_time_ms_o)
    tick(1);
    `CHK("segment pulse end", 1'b0, seg_valid_o)
  endtask : run_seg

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  //////////////////////////////////////////////////////////////////////////////
  // Expected run is near 21.4k clocks
  initial begin
    tick(60000);
    err_count++;
    $display("Watchdog expired before the tests ended");
    complete_run();
  end

  initial begin
    logic [7:0] rx;
    logic       a;
    tick(5);
    sys_rst_i = 1'b0;
    tick(4);
    `CHK("full scale after reset", 8'h3e, full_scale_ref_o)
    `CHK("rated copy after reset", 8'h3e, cal_rated_o)
    check_reg(`HWT_OFS_NEG_SUS, 8'h00, "neg sustain reset");
    check_reg(`HWT_OFS_BRAKE, 8'h00, "brake reset");
    check_reg(`HWT_OFS_RATED, 8'h3e, "rated reset");
    check_reg(`HWT_OFS_CLAMP, 8'h9b, "clamp reset");
    check_reg(`HWT_OFS_CAL_COMP, `HWT_RST_CAL_COMP, "comp reset");
    check_reg(`HWT_OFS_CAL_BEMF, `HWT_RST_CAL_BEMF, "bemf reset");
    check_reg(8'h20, `HWT_RD_UNMAPPED, "unmapped read");
    // Foreign device address must be left unanswered
    bus_start();
    byte_io({7'h2b, 1'b0}, rx, a);
    bus_stop();
    `CHK("foreign address ack", 1'b0, a)
    $display("Test reset_values done");

    reg_write(`HWT_OFS_RATED, 8'h50);
    tick(2);
    `CHK("rated copy", 8'h50, cal_rated_o)
    `CHK("stale after write", 1'b1, cal_stale_o)
    check_reg(`HWT_OFS_RATED, 8'h50, "rated readback");
    cal_comp_i                    = 8'h21;
    calibration_back_emf_result_i = 8'h43;
    cal_done_i                    = 1'b1;
    tick(1);
    cal_done_i = 1'b0;
    tick(2);
    `CHK("stale after calibration", 1'b0, cal_stale_o)
    check_reg(`HWT_OFS_CAL_COMP, 8'h21, "comp result");
    check_reg(`HWT_OFS_CAL_BEMF, 8'h43, "bemf result");
    reg_write(`HWT_OFS_CLAMP, 8'hc0);
    check_reg(`HWT_OFS_CLAMP, 8'hc0, "clamp readback");
    $display("Test calibration_regs done");

    ref_case(1'b0, 1'b0, 8'hff, 8'h50, 8'h50);
    ref_case(1'b0, 1'b1, 8'hff, 8'hc0, 8'h50);
    ref_case(1'b1, 1'b0, 8'hff, 8'hc0, 8'hc0);
    ref_case(1'b1, 1'b0, 8'h10, 8'h10, 8'hc0);
    $display("Test references done");

    reg_write(`HWT_OFS_NEG_SUS, 8'hfe);
    reg_write(`HWT_OFS_BRAKE, 8'h03);
    run_seg(8'hfd, 8'h0a, 8'h50, 8'hf7, 1'b0, HWT_CLS_NEG_SUS, 17'h28);
    run_seg(8'hfd, 8'h01, 8'h50, 8'hf7, 1'b0, HWT_CLS_NEG_SUS, 17'h00);
    run_seg(8'hf7, 8'h0a, 8'h50, 8'hf7, 1'b1, HWT_CLS_BRAKE, 17'h41);
    run_seg(8'hf7, 8'h0a, 8'h50, 8'hf7, 1'b0, HWT_CLS_BRAKE, 17'h32);
    run_seg(8'h50, 8'h04, 8'h50, 8'hf7, 1'b0, HWT_CLS_OVERDRV, 17'h14);
    run_seg(8'hfe, 8'h03, 8'hfe, 8'hf7, 1'b0, HWT_CLS_OVERDRV, 17'h0f);
    run_seg(8'h14, 8'h06, 8'h50, 8'hf7, 1'b0, HWT_CLS_POS_SUS, 17'h1e);
    // Zero drive is neither sustain nor brake and keeps its time
    run_seg(8'h00, 8'h02, 8'h50, 8'hf7, 1'b0, HWT_CLS_IDLE, 17'h0a);
    reg_write(`HWT_OFS_BRAKE, 8'hfb);
    run_seg(8'hf7, 8'h0a, 8'h50, 8'hf7, 1'b1, HWT_CLS_BRAKE, 17'h19);
    $display("Test segments done");
    complete_run();
  end

endmodule : hwt_regs_test
